// [adcp_defines.svh]
/*
 * Register indices, field positions, reset values and cycle counts of the
 * converter control block. Included by the top module only.
 */
`ifndef ADCP_DEFINES_SVH
`define ADCP_DEFINES_SVH

// register indices, byte address is four times the index
`define ADCP_IDX_RES_LO   8'h04
`define ADCP_IDX_RES_HI   8'h05
`define ADCP_IDX_CSRA     8'h06
`define ADCP_IDX_MUX      8'h07
`define ADCP_IDX_CSRB     8'h08
`define ADCP_IDX_IRQ_STAT 8'h09
`define ADCP_IDX_IRQ_MASK 8'h0A

// control/status a fields
`define ADCP_CSRA_EN      7
`define ADCP_CSRA_START   6
`define ADCP_CSRA_ATE     5
`define ADCP_CSRA_DONE    4
`define ADCP_CSRA_IE      3
`define ADCP_CSRA_PS_HI   2
`define ADCP_CSRA_PS_LO   0

// multiplexer select fields
`define ADCP_MUX_REF_HI   7
`define ADCP_MUX_REF_LO   6
`define ADCP_MUX_LALIGN   5
`define ADCP_MUX_CH_HI    4
`define ADCP_MUX_CH_LO    0

// control b and interrupt status fields
`define ADCP_CSRB_TS_HI   2
`define ADCP_CSRB_TS_LO   0
`define ADCP_IRQ_DONE     0
`define ADCP_IRQ_ABORT    1

// reset values
`define ADCP_RST_BYTE     8'h00
`define ADCP_RST_WORD     32'h0000_0000

// conversion lengths in converter clock cycles
`define ADCP_CYC_FIRST    5'd25
`define ADCP_CYC_NORMAL   5'd13

// trigger source code meaning free running
`define ADCP_TS_FREE      3'h0

`endif

// [adcp_pkg.sv]
/*
 * Types of the converter control block.
 * Does not include adcp_defines.svh.
 */
`default_nettype none

package adcp_pkg;

  // conversion sequencer states
  typedef enum logic [0:0] {
    ADCP_IDLE = 1'b0,
    ADCP_CONV = 1'b1
  } adcp_state_t;

  // signals towards the analog converter
  typedef struct packed {
    logic       power;      // converter_power_on
    logic       conv_clk;   // prescaled converter clock
    logic       sample;     // one-cycle pulse at conversion start
    logic [1:0] ref_sel;    // reference_select in use
    logic [4:0] ch_sel;     // channel_gain_select in use
  } adcp_analog_t;

endpackage : adcp_pkg

`default_nettype wire

// [adcp_top.sv]
/*
 * Control, status and prescaler logic of a successive-approximation
 * converter, reached over an AHB-Lite slave port.
 * Assumes a single hclk domain, a synchronous sample input, trigger inputs that are synchronised here, and
 * an analog core that holds its 10-bit sample valid when a conversion ends.
 */
// Overview of operation
// R01: enable bit powers converter on or off
// R02: clearing enable aborts running conversion at once
// R03: single mode: each start write converts once
// R04: free running: start once, then self restart
// R05: first conversion 25 cycles, later 13
// R06: start bit reads one while converting
// R07: writing zero to start is ignored
// R08: auto trigger starts on selected rising edge
// R09: trigger source chosen in control b register
// R10: done flag set with result update
// R11: interrupt needs flag, enable and global enable
// R12: vector acknowledge clears done flag
// R13: writing one clears done flag
// R14: software avoids read-modify-write on control register
// R15: prescaler divides by 2 to 128
// R16: alignment bit left or right adjusts result
// R17: selection changes apply after conversion completes
// R18: trigger synchronised, edge detected once
// R19: resets to zero, prescaler held when disabled
`timescale 1ns/1ps
`default_nettype none
`include "adcp_defines.svh"

module adcp_top (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // trigger sources and processor side
  input  wire logic [7:0]        trigger_in,
  input  wire logic              global_irq_enable,
  input  wire logic              irq_vector_ack,
  // analog core
  input  wire logic [9:0]        conv_sample,
  output adcp_pkg::adcp_analog_t analog_out,
  // interrupts
  output logic                   conv_irq,
  output logic                   irq
);
  import adcp_pkg::*;

  // register state
  logic              en_q, ate_q, done_q, ie_q;
  logic [2:0]        ps_q;
  logic [7:0]        mux_q;
  logic [2:0]        ts_q;
  logic [9:0]        result_q;
  logic [1:0]        stat_q, mask_q;
  logic [6:0]        applied_q;
  // sequencer state
  adcp_state_t       state_q, state_d;
  logic [4:0]        cyc_q;
  logic              first_q, long_q;
  logic [6:0]        pre_q, pre_d;
  // bus phase registers
  logic              wr_pend_q;
  logic [7:0]        wr_idx_q;
  // trigger synchroniser
  logic              trig_s1_q, trig_s2_q, trig_prev_q;
  // output flops
  logic [31:0]       hrdata_q;
  adcp_analog_t      analog_q;
  logic              conv_irq_q, irq_q;

  // bus decode
  logic              addr_ok, rd_take, wr_take;
  logic [7:0]        addr_idx;
  logic              wr_csra, wr_mux, wr_csrb, wr_mask;
  logic [7:0]        wbyte;
  logic              rd_stat;

  assign addr_ok  = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  assign addr_idx = haddr[9:2];
  assign rd_take  = hsel && hready && htrans[1] && !hwrite;
  assign wr_take  = hsel && hready && htrans[1] && hwrite && addr_ok;
  assign rd_stat  = rd_take && addr_ok && (addr_idx == `ADCP_IDX_IRQ_STAT);
  assign wbyte    = hwdata[7:0];
  assign wr_csra  = wr_pend_q && (wr_idx_q == `ADCP_IDX_CSRA);
  assign wr_mux   = wr_pend_q && (wr_idx_q == `ADCP_IDX_MUX);
  assign wr_csrb  = wr_pend_q && (wr_idx_q == `ADCP_IDX_CSRB);
  assign wr_mask  = wr_pend_q && (wr_idx_q == `ADCP_IDX_IRQ_MASK);

  // write address phase captured, data applied one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= `ADCP_RST_BYTE;
    end else begin
      wr_pend_q <= wr_take;
      wr_idx_q  <= addr_idx;
    end
  end

  // next enable value, seen in the same cycle as the write
  logic en_d;
  assign en_d = wr_csra ? wbyte[`ADCP_CSRA_EN] : en_q;

  // R01 enable bit control
  // R19 all bits reset to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q  <= 1'b0;
      ate_q <= 1'b0;
      ie_q  <= 1'b0;
      ps_q  <= 3'h0;
    end else if (wr_csra) begin
      en_q  <= wbyte[`ADCP_CSRA_EN];
      ate_q <= wbyte[`ADCP_CSRA_ATE];
      ie_q  <= wbyte[`ADCP_CSRA_IE];
      ps_q  <= wbyte[`ADCP_CSRA_PS_HI:`ADCP_CSRA_PS_LO];
    end
  end

  // selection and trigger source registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mux_q  <= `ADCP_RST_BYTE;
      ts_q   <= 3'h0;
      mask_q <= 2'h0;
    end else begin
      if (wr_mux) begin
        mux_q <= wbyte;
      end
      // R09 trigger source select
      if (wr_csrb) begin
        ts_q <= wbyte[`ADCP_CSRB_TS_HI:`ADCP_CSRB_TS_LO];
      end
      if (wr_mask) begin
        mask_q <= wbyte[1:0];
      end
    end
  end

  // R15 division shift: codes 0 and 1 both divide by 2
  logic [2:0] shift;
  logic [6:0] pre_top;
  logic       tick;
  assign shift   = (ps_q < 3'h2) ? 3'h1 : ps_q;
  assign pre_top = 7'((8'h01 << shift) - 8'h01);
  assign tick    = en_q && (pre_q == pre_top);

  // R19 prescaler held at zero while disabled
  always_comb begin
    if (!en_q || tick || (pre_q > pre_top)) begin
      pre_d = 7'h00;
    end else begin
      pre_d = 7'(pre_q + 7'h01);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= 7'h00;
    end else begin
      pre_q <= pre_d;
    end
  end

  // R18 two-flop synchroniser, edge seen from the second stage only
  logic trig_sel, trig_edge;
  assign trig_sel  = trigger_in[ts_q];
  assign trig_edge = trig_s2_q && !trig_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_s1_q   <= 1'b0;
      trig_s2_q   <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      trig_s1_q   <= trig_sel;
      trig_s2_q   <= trig_s1_q;
      trig_prev_q <= trig_s2_q;
    end
  end

  // start and finish conditions
  logic sw_start, free_mode, hw_start, start, finish, abort;
  logic [4:0] len;
  // R07 only a written one to the start bit gives a software start
  assign sw_start  = wr_csra && wbyte[`ADCP_CSRA_START];
  assign free_mode = ate_q && (ts_q == `ADCP_TS_FREE);
  // R08 auto trigger on selected edge
  assign hw_start  = ate_q && !free_mode && trig_edge;
  // R05 first conversion carries initialisation
  assign len       = long_q ? `ADCP_CYC_FIRST : `ADCP_CYC_NORMAL;
  assign finish    = (state_q == ADCP_CONV) && en_d && tick && (cyc_q == 5'(len - 5'd1));
  // R02 disable aborts a running conversion
  assign abort     = (state_q == ADCP_CONV) && !en_d;
  // R03 single start per write
  assign start     = en_d && (state_q == ADCP_IDLE) && (sw_start || hw_start);

  // sequencer next state
  always_comb begin
    case (state_q)
      ADCP_IDLE: begin
        state_d = start ? ADCP_CONV : ADCP_IDLE;
      end
      ADCP_CONV: begin
        if (abort) begin
          state_d = ADCP_IDLE;
        // R04 free running restarts on its own
        end else if (finish && !free_mode) begin
          state_d = ADCP_IDLE;
        end else begin
          state_d = ADCP_CONV;
        end
      end
      default: begin
        state_d = ADCP_IDLE;
      end
    endcase
  end

  // sequencer state and converter cycle count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ADCP_IDLE;
      cyc_q   <= 5'd0;
      long_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start || finish || abort) begin
        cyc_q <= 5'd0;
      end else if ((state_q == ADCP_CONV) && tick) begin
        cyc_q <= 5'(cyc_q + 5'd1);
      end
      if (start) begin
        long_q <= first_q;
      end else if (finish) begin
        long_q <= 1'b0;
      end
    end
  end

  // R05 first-conversion marker rearmed while disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_q <= 1'b1;
    end else if (!en_d) begin
      first_q <= 1'b1;
    end else if (start) begin
      first_q <= 1'b0;
    end
  end

  // R10 result taken with the done flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= 10'h000;
    end else if (finish) begin
      result_q <= conv_sample;
    end
  end

  // R10 flag set on finish; set wins over clears
  // R12 vector acknowledge clears
  // R13 written one clears, zero keeps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (irq_vector_ack || (wr_csra && wbyte[`ADCP_CSRA_DONE])) begin
      done_q <= 1'b0;
    end
  end

  // R17 selection applied only while idle or at completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      applied_q <= 7'h00;
    end else if ((state_q == ADCP_IDLE && !start) || finish) begin
      applied_q <= {mux_q[`ADCP_MUX_REF_HI:`ADCP_MUX_REF_LO], mux_q[`ADCP_MUX_CH_HI:`ADCP_MUX_CH_LO]};
    end
  end

  // sticky event status, cleared by reading; events win over the read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= (rd_stat ? 2'h0 : stat_q) | {abort, finish};
    end
  end

  // R16 result alignment follows the bit at once
  logic [7:0] res_lo, res_hi;
  assign res_lo = mux_q[`ADCP_MUX_LALIGN] ? {result_q[1:0], 6'h00} : result_q[7:0];
  assign res_hi = mux_q[`ADCP_MUX_LALIGN] ? result_q[9:2] : {6'h00, result_q[9:8]};

  // read mux; unmapped addresses read zero
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = `ADCP_RST_BYTE;
    if (addr_ok) begin
      case (addr_idx)
        `ADCP_IDX_RES_LO:   rd_byte = res_lo;
        `ADCP_IDX_RES_HI:   rd_byte = res_hi;
        // R06 start bit shows busy
        `ADCP_IDX_CSRA:     rd_byte = {en_q, (state_q == ADCP_CONV), ate_q, done_q, ie_q, ps_q};
        `ADCP_IDX_MUX:      rd_byte = mux_q;
        `ADCP_IDX_CSRB:     rd_byte = {5'h00, ts_q};
        `ADCP_IDX_IRQ_STAT: rd_byte = {6'h00, stat_q};
        `ADCP_IDX_IRQ_MASK: rd_byte = {6'h00, mask_q};
        default:            rd_byte = `ADCP_RST_BYTE;
      endcase
    end
  end

  // read data registered into the data phase; zero wait, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= `ADCP_RST_WORD;
    end else if (rd_take) begin
      hrdata_q <= {24'h000000, rd_byte};
    end
  end

  // R11 completion interrupt gated by enable and global enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_irq_q <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      conv_irq_q <= done_q && ie_q && global_irq_enable;
      irq_q      <= |(stat_q & mask_q);
    end
  end

  // analog side: power, clock phase, start pulse, frozen selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_q <= '0;
    end else begin
      analog_q.power    <= en_d;
      analog_q.conv_clk <= en_q && pre_d[shift - 3'h1];
      analog_q.sample   <= start || (finish && free_mode); // free running restarts need a pulse too
      analog_q.ref_sel  <= applied_q[6:5];
      analog_q.ch_sel   <= applied_q[4:0];
    end
  end

  assign hrdata     = hrdata_q;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign analog_out = analog_q;
  assign conv_irq   = conv_irq_q;
  assign irq        = irq_q;

endmodule // adcp_top

`default_nettype wire

// [adcp_top_props.sv]
/* port checker of adcp_top: bus answer, interrupt gating, converter pulses.
   assumes one hclk domain and attachment by the bind at the foot. */
`timescale 1ns/1ps
`default_nettype none
module adcp_top_props (
  // clock and reset
  input wire logic                   hclk,
  input wire logic                   hresetn,
  // bus and processor side
  input wire logic                   hsel,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic                   global_irq_enable,
  // watched outputs
  input wire adcp_pkg::adcp_analog_t analog_out,
  input wire logic                   conv_irq,
  input wire logic                   irq
);
  import adcp_pkg::*;
  logic [7:0] gap_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // cycles since last sample pulse; power loss forgets it, an abort may restart early
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gap_q <= 8'hFF;
    else if (analog_out.sample) gap_q <= 8'h00;
    else if (!analog_out.power) gap_q <= 8'hFF;
    else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
  end
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_rdata_stands: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_irq_gated: assert property (conv_irq |-> $past(global_irq_enable))
    else $error("conversion irq without global enable");
  a_gie_off_quiet: assert property (!global_irq_enable |=> !conv_irq)
    else $error("conversion irq stayed up after global disable");
  a_clk_held_off: assert property (!analog_out.power [*2] |-> !analog_out.conv_clk)
    else $error("converter clock runs while disabled");
  a_sample_powered: assert property (analog_out.sample |-> analog_out.power)
    else $error("sample pulse while converter off");
  a_sample_pulse: assert property (analog_out.sample |=> !analog_out.sample)
    else $error("sample pulse longer than one cycle");
  a_conv_gap: assert property (analog_out.sample |-> gap_q >= 8'd23)
    else $error("conversions closer than thirteen ticks");
  c_sample: cover property (analog_out.sample);
  c_conv_irq: cover property ($rose(conv_irq));
  c_irq: cover property ($rose(irq));
endmodule // adcp_top_props

bind adcp_top adcp_top_props u_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .global_irq_enable, .analog_out, .conv_irq, .irq);
`default_nettype wire

// [adcp_top_test.sv]
/* self-checking bench of adcp_top through its ahb-lite port.
   assumes the design files and adcp_top_props.sv are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module adcp_top_test;
  import adcp_pkg::*;
  typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e;} adcp_row_t;
  logic         hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic         global_irq_enable, irq_vector_ack, conv_irq, irq;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  haddr, hwdata, hrdata, r;
  logic [7:0]   trigger_in;
  logic [9:0]   conv_sample;
  adcp_analog_t analog_out;
  int           fails, tests_run, cyc, n, d, samples;
  adcp_row_t    rows [7];

  // single slave: its ready is the bus ready
  assign hready = hreadyout;

  adcp_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .trigger_in, .global_irq_enable, .irq_vector_ack, .conv_sample, .analog_out,
    .conv_irq, .irq);

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // timeout and count of sample pulses
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (analog_out.sample === 1'b1) samples <= samples + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single transfer, entered right after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  // writes end with one idle cycle; a read right behind a write would already see the new value
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
    @(posedge hclk);
  endtask

  task automatic rd(input logic [31:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  // cycles from the next sample pulse until the interrupt rises
  task automatic timed(output int k);
    k = 0;
    while (analog_out.sample !== 1'b1) @(posedge hclk);
    while (conv_irq !== 1'b1) begin
      @(posedge hclk);
      k++;
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    {hresetn, hsel, hwrite, global_irq_enable, irq_vector_ack} = 5'h00;
    {haddr, hwdata, htrans, hsize, trigger_in, conv_sample} = '0;
    rows = '{'{32'h1C, 32'h41, 32'h41}, '{32'h20, 32'h05, 32'h05}, '{32'h28, 32'h03, 32'h03},
             '{32'h18, 32'h07, 32'h07}, '{32'h14, 32'hFF, 32'h00}, '{32'h24, 32'hFF, 32'h00},
             '{32'h400, 32'hFF, 32'h00}};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset value, then write and read back
    foreach (rows[i]) begin
      rd(rows[i].a);
      check(r, 32'h0);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      check(r, rows[i].e);
    end
    // first conversion after enable, divide by two
    conv_sample <= 10'h2A5;
    global_irq_enable <= 1'b1;
    wr(32'h18, 32'hC8);
    timed(n);
    check(32'(n >= 24 * 2 && n <= 25 * 2 + 2), 32'h1);
    rd(32'h18);
    check(r, 32'h98);
    rd(32'h10);
    check(r, 32'hA5);
    rd(32'h14);
    check(r, 32'h02);
    check(irq, 1'b1);
    rd(32'h24);
    check(r, 32'h01);
    rd(32'h24);
    check(r, 32'h00);
    check(irq, 1'b0);
    wr(32'h1C, 32'h61);
    rd(32'h14);
    check(r, 32'hA9);
    rd(32'h10);
    check(r, 32'h40);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge hclk);
    check(conv_irq, 1'b0);
    global_irq_enable <= 1'b1;
    irq_vector_ack <= 1'b1;
    @(posedge hclk);
    irq_vector_ack <= 1'b0;
    rd(32'h18);
    check(r[4], 1'b0);
    // later conversion is thirteen ticks
    wr(32'h1C, 32'h41);
    wr(32'h18, 32'hC8);
    timed(n);
    check(32'(n >= 12 * 2 && n <= 13 * 2 + 2), 32'h1);
    // whole-register writes, done written as zero, then as one
    wr(32'h18, 32'h88);
    rd(32'h18);
    check(r[4], 1'b1);
    wr(32'h18, 32'h98);
    rd(32'h18);
    check(r, 32'h88);
    // mid-conversion writes: selection frozen, start zero ignored, done masked
    wr(32'h28, 32'h02);
    wr(32'h18, 32'hC8);
    wr(32'h1C, 32'h46);
    check(analog_out.ch_sel, 5'h01);
    wr(32'h18, 32'h88);
    rd(32'h18);
    check(r[6], 1'b1);
    while (conv_irq !== 1'b1) @(posedge hclk);
    @(posedge hclk);
    check({analog_out.ref_sel, analog_out.ch_sel}, 7'h26);
    check(irq, 1'b0);
    // prescaler codes 1 to 7, from a fresh enable each time
    for (int c = 1; c < 8; c++) begin
      d = (c < 2) ? 2 : (1 << c);
      wr(32'h18, 32'h10 | c);
      wr(32'h18, 32'hC8 | c);
      timed(n);
      check(32'(n >= 24 * d && n <= 25 * d + 2), 32'h1);
    end
    // free running, then abort by disable
    wr(32'h20, 32'h00);
    wr(32'h18, 32'hF8);
    n = samples;
    repeat (120) @(posedge hclk);
    check(32'(samples - n >= 3), 32'h1);
    wr(32'h18, 32'h08);
    rd(32'h18);
    check(r[6], 1'b0);
    rd(32'h24);
    check(r[1], 1'b1);
    // auto trigger on source three only
    wr(32'h20, 32'h03);
    wr(32'h18, 32'hB8);
    n = samples;
    trigger_in <= 8'h04;
    repeat (60) @(posedge hclk);
    check(32'(samples - n), 32'h0);
    trigger_in <= 8'h0C;
    repeat (8) @(posedge hclk);
    wr(32'h18, 32'hA8);
    rd(32'h18);
    check(r[6], 1'b1);
    repeat (150) @(posedge hclk);
    check(32'(samples - n), 32'h1);
    // mid-run reset returns control a, mask register, power and both interrupts to zero
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(32'h18);
    check(r, 32'h0);
    rd(32'h28);
    check(r, 32'h0);
    check({analog_out.power, conv_irq, irq}, 3'h0);
    final_report();
  end
endmodule // adcp_top_test
`default_nettype wire
